/* File: design/pad_cfg_pkg.sv */
// constants for the pin input-type and output-strength register bank
// assumes the core drives the page select from its own paging register
package pad_cfg_pkg;

    // --------------------------------------------------------------
    // pages
    // --------------------------------------------------------------
    localparam logic PAGE_0 = 1'b0;
    localparam logic PAGE_1 = 1'b1;

    // --------------------------------------------------------------
    // offsets, index 0 is port 0 and index 5 is port 5
    // --------------------------------------------------------------
    localparam logic [5:0][7:0] TYPE_ADDR = {
        8'hdc, 8'hda, 8'hac, 8'hb5, 8'hb3, 8'hb1
    };
    localparam logic [7:0] DRIVE_ADDR = 8'hb4;
    localparam logic [7:0] MODE_FIRST_ADDR = 8'hb3;
    localparam int P1_IDX = 1;

    // --------------------------------------------------------------
    // writable bits and reset values
    // --------------------------------------------------------------
    localparam logic [5:0][7:0] TYPE_WMASK = {
        8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff
    };
    localparam logic [5:0][7:0] TYPE_RST = '0;
    localparam int DRIVE_W = 4;
    localparam logic [DRIVE_W-1:0] DRIVE_RST = 4'h0;
    localparam logic [7:0] MODE_FIRST_RST = 8'hff;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic sfr_hit(input logic [7:0] addr,
                                     input logic page,
                                     input logic [7:0] off,
                                     input logic pg);
        return (addr == off) && (page == pg);
    endfunction

    // push-pull is first mode bit 0 with second mode bit 1
    function automatic logic [DRIVE_W-1:0] push_pull(
        input logic [DRIVE_W-1:0] first,
        input logic [DRIVE_W-1:0] second);
        return ~first & second;
    endfunction

endpackage

/* File: design/pad_cfg_if.sv */
// carrier for register contents from the bank to the pad driver stage
// assumes both ends share one clock
`timescale 1ns/1ps
interface pad_cfg_if;
    import pad_cfg_pkg::*;
    logic [5:0][7:0] input_type;
    logic [DRIVE_W-1:0] drive;
    logic [7:0] mode_first;
    modport bank (output input_type, output drive, output mode_first);
    modport pads (input input_type, input drive, input mode_first);
endinterface

/* File: design/pad_drive_out.sv */
// registered pad controls from the bank contents
// assumes the second port 1 mode register arrives on the same clock
`timescale 1ns/1ps
module pad_drive_out
    import pad_cfg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register contents
    pad_cfg_if.pads cfg,
    input wire logic [DRIVE_W-1:0] p1_mode_second,
    // pad controls
    output logic [5:0][7:0] schmitt_en,
    output logic [DRIVE_W-1:0] strength_large
);

    // --------------------------------------------------------------
    // next values
    // --------------------------------------------------------------
    logic [5:0][7:0] nxt_schmitt_en;
    logic [DRIVE_W-1:0] nxt_strength_large;

    always_comb begin
        nxt_schmitt_en = cfg.input_type;
        nxt_strength_large = cfg.drive
            & push_pull(cfg.mode_first[DRIVE_W-1:0], p1_mode_second);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            schmitt_en <= TYPE_RST;
            strength_large <= DRIVE_RST;
        end else begin
            schmitt_en <= nxt_schmitt_en;
            strength_large <= nxt_strength_large;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_SCHMITT_FOLLOWS: assert property (
        @(posedge clock) disable iff (reset)
        schmitt_en[P1_IDX] == $past(cfg.input_type[P1_IDX]))
        else $error("schmitt enable does not follow input type");

    AST_STRENGTH_PUSH_PULL: assert property (
        @(posedge clock) disable iff (reset)
        (cfg.mode_first[0] || !p1_mode_second[0]) |=> !strength_large[0])
        else $error("large strength outside push-pull mode");

    AST_STRENGTH_LARGE: assert property (
        @(posedge clock) disable iff (reset)
        (cfg.drive[2] && !cfg.mode_first[2] && p1_mode_second[2])
        |=> strength_large[2])
        else $error("large strength not applied");

endmodule

/* File: design/pad_cfg_bank.sv */
// input-type and output-strength register bank on the core's sfr bus
// assumes the core supplies page, address and strobes on the same clock
`timescale 1ns/1ps
module pad_cfg_bank
    import pad_cfg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // sfr bus from the core
    input wire logic sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    // port 1 second mode bits, pins 0-3
    input wire logic [DRIVE_W-1:0] p1_mode_second,
    // pad controls
    output logic [5:0][7:0] schmitt_en,
    output logic [DRIVE_W-1:0] strength_large,
    output logic [7:0] p1_mode_first
);

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [5:0][7:0] in_type_ff;
    logic [5:0][7:0] nxt_in_type;
    logic [DRIVE_W-1:0] drive_ff;
    logic [DRIVE_W-1:0] nxt_drive;
    logic [7:0] mode_first_ff;
    logic [7:0] nxt_mode_first;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    pad_cfg_if cfg ();

    always_comb begin
        nxt_in_type = in_type_ff;
        nxt_drive = drive_ff;
        nxt_mode_first = mode_first_ff;
        for (int i = 0; i < 6; i++) begin
            if (sfr_wr && sfr_hit(sfr_addr, sfr_page,
                                  TYPE_ADDR[i], PAGE_1)) begin
                nxt_in_type[i] = sfr_wdata & TYPE_WMASK[i];
            end
        end
        if (sfr_wr && sfr_hit(sfr_addr, sfr_page,
                              DRIVE_ADDR, PAGE_1)) begin
            nxt_drive = sfr_wdata[DRIVE_W-1:0];
        end
        if (sfr_wr && sfr_hit(sfr_addr, sfr_page,
                              MODE_FIRST_ADDR, PAGE_0)) begin
            nxt_mode_first = sfr_wdata;
        end
    end

    // --------------------------------------------------------------
    // read path, unmapped addresses read as zero
    // --------------------------------------------------------------
    always_comb begin
        nxt_rdata = RDATA_RST;
        nxt_rvalid = sfr_rd;
        if (sfr_rd) begin
            for (int i = 0; i < 6; i++) begin
                if (sfr_hit(sfr_addr, sfr_page, TYPE_ADDR[i], PAGE_1)) begin
                    nxt_rdata = in_type_ff[i];
                end
            end
            if (sfr_hit(sfr_addr, sfr_page, DRIVE_ADDR, PAGE_1)) begin
                nxt_rdata = {{(8-DRIVE_W){1'b0}}, drive_ff};
            end
            if (sfr_hit(sfr_addr, sfr_page, MODE_FIRST_ADDR, PAGE_0)) begin
                nxt_rdata = mode_first_ff;
            end
        end
    end

    // --------------------------------------------------------------
    // register updates
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            in_type_ff <= TYPE_RST;
            drive_ff <= DRIVE_RST;
            mode_first_ff <= MODE_FIRST_RST;
        end else begin
            in_type_ff <= nxt_in_type;
            drive_ff <= nxt_drive;
            mode_first_ff <= nxt_mode_first;
        end
    end

    // --------------------------------------------------------------
    // one-cycle read answer
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_ff <= RDATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign sfr_rvalid = rvalid_ff;
    assign p1_mode_first = mode_first_ff;
    assign cfg.input_type = in_type_ff;
    assign cfg.drive = drive_ff;
    assign cfg.mode_first = mode_first_ff;

    // --------------------------------------------------------------
    // pad driver stage
    // --------------------------------------------------------------
    pad_drive_out u_pads (
        .clock(clock),
        .reset(reset),
        .cfg(cfg.pads),
        .p1_mode_second(p1_mode_second),
        .schmitt_en(schmitt_en),
        .strength_large(strength_large)
    );

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_PAGE0_KEEPS_TYPES: assert property (
        (sfr_wr && sfr_page == PAGE_0) |=>
        ($stable(in_type_ff) && $stable(drive_ff)))
        else $error("page 0 write changed page 1 register");

    AST_PIN_INDEPENDENT: assert property (
        (sfr_wr && sfr_page == PAGE_1 && sfr_addr == TYPE_ADDR[P1_IDX])
        |=> (in_type_ff[P1_IDX] == $past(sfr_wdata)) && $stable(in_type_ff[2]))
        else $error("input type write wrong or disturbed another port");

    AST_TYPE_RESET: assert property (
        disable iff (1'b0)
        reset |=> (in_type_ff[1] == 8'h00 && in_type_ff[2] == 8'h00
                   && in_type_ff[3] == 8'h00 && in_type_ff[5] == 8'h00))
        else $error("input type register not cleared by reset");

    AST_DRIVE_WRITE: assert property (
        (sfr_wr && sfr_page == PAGE_1 && sfr_addr == DRIVE_ADDR)
        |=> drive_ff == $past(sfr_wdata[3:0]))
        else $error("strength write not taken");

    AST_PAGE1_B3_NOT_MODE: assert property (
        (sfr_wr && sfr_page == PAGE_1 && sfr_addr == MODE_FIRST_ADDR)
        |=> $stable(mode_first_ff))
        else $error("page 1 write reached mode register");

    AST_MODE_FIRST_RESET: assert property (
        disable iff (1'b0)
        reset |=> mode_first_ff == 8'hff)
        else $error("mode register reset value wrong");

    AST_MODE_FIRST_READ: assert property (
        (sfr_rd && sfr_page == PAGE_0 && sfr_addr == MODE_FIRST_ADDR)
        |=> (sfr_rvalid && sfr_rdata == $past(mode_first_ff)))
        else $error("mode register read wrong");

    AST_RESERVED_ZERO: assert property (
        (sfr_rd && sfr_page == PAGE_1
         && (sfr_addr == TYPE_ADDR[3] || sfr_addr == TYPE_ADDR[4]
             || sfr_addr == DRIVE_ADDR))
        |=> (sfr_rvalid && !sfr_rdata[7]
             && ($past(sfr_addr) != DRIVE_ADDR || sfr_rdata[6:4] == 3'h0)))
        else $error("reserved bit read as one");

    AST_P3_BIT7_ZERO: assert property (
        (in_type_ff[3][7] == 1'b0) && (in_type_ff[4][7] == 1'b0))
        else $error("reserved input type bit stored");

    AST_TYPE_READ: assert property (
        (sfr_rd && sfr_page == PAGE_1 && sfr_addr == TYPE_ADDR[P1_IDX])
        |=> (sfr_rvalid && sfr_rdata == $past(in_type_ff[P1_IDX])))
        else $error("input type read wrong");

    AST_WR_OTHER_PORTS: assert property (
        (sfr_wr && sfr_page == PAGE_1 && sfr_addr == TYPE_ADDR[P1_IDX])
        |=> ($stable(in_type_ff[0]) && $stable(in_type_ff[5])
             && $stable(drive_ff)))
        else $error("port 1 type write disturbed another register");

    AST_TYPE_WRITE_MASK: assert property (
        (sfr_wr && sfr_page == PAGE_1 && sfr_addr == TYPE_ADDR[4])
        |=> in_type_ff[4] == {1'b0, $past(sfr_wdata[6:0])})
        else $error("reserved port 4 type bit stored");

    AST_DRIVE_READ: assert property (
        (sfr_rd && sfr_page == PAGE_1 && sfr_addr == DRIVE_ADDR)
        |=> (sfr_rvalid && sfr_rdata[7:4] == 4'h0
             && sfr_rdata[3:0] == $past(drive_ff)))
        else $error("strength read wrong");

    AST_MODE_FIRST_WRITE: assert property (
        (sfr_wr && sfr_page == PAGE_0 && sfr_addr == MODE_FIRST_ADDR)
        |=> mode_first_ff == $past(sfr_wdata))
        else $error("mode register write not taken");

    AST_PAGE0_READ_ZERO: assert property (
        (sfr_rd && sfr_page == PAGE_0 && sfr_addr != MODE_FIRST_ADDR)
        |=> (sfr_rvalid && sfr_rdata == 8'h00))
        else $error("page 0 read reached a page 1 register");

endmodule

/* File: dv/sfr_core_model.sv */
// core-side model of the sfr bus: single-byte writes and reads
// assumes the bank answers a read one cycle after the strobe edge
`timescale 1ns/1ps
module sfr_core_model (
    // clock
    input wire logic clock,
    // sfr bus to the bank
    output logic sfr_page,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid
);
    // --------------------------------------------------------------
    // bus cycles
    // --------------------------------------------------------------
    initial begin
        sfr_page = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    // released address and data show the inverse, not the stale value
    task automatic wr(input logic pg, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clock);
        sfr_page <= pg;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask
    task automatic rd(input logic pg, input logic [7:0] a,
                      output logic [7:0] d, output logic v);
        @(posedge clock);
        sfr_page <= pg;
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        @(posedge clock);
        d = sfr_rdata;
        v = sfr_rvalid;
    endtask
endmodule

/* File: dv/pin_input_type_strength_regs_tb.sv */
// testbench for the input-type and output-strength register bank
// assumes the core model issues all register traffic
`timescale 1ns/1ps
module pin_input_type_strength_regs_tb;
    import pad_cfg_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sfr_page, sfr_wr, sfr_rd, sfr_rvalid;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p1_mode_first;
    logic [3:0] p1_mode_second = 4'h0;
    logic [3:0] strength_large;
    logic [5:0][7:0] schmitt_en;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    pad_cfg_bank u_dut (.clock, .reset, .sfr_page, .sfr_addr, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rvalid, .p1_mode_second,
        .schmitt_en, .strength_large, .p1_mode_first);
    sfr_core_model u_core (.clock, .sfr_page, .sfr_addr, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rvalid);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic pg, input logic [7:0] a,
                        input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_core.rd(pg, a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask
    function automatic logic [7:0] tval(input int i);
        return (8'hc3 ^ 8'(i)) & ((i == 3 || i == 4) ? 8'h7f : 8'hff);
    endfunction
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            final_report();
        end
    end
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            check(schmitt_en[i], 8'h00);
            rchk(PAGE_1, TYPE_ADDR[i], 8'h00);
        end
        rchk(PAGE_1, DRIVE_ADDR, 8'h00);
        rchk(PAGE_0, 8'hb3, 8'hff);
        check(p1_mode_first, 8'hff);
        // distinct value per port, reserved bit 7 set in all
        for (int i = 0; i < 6; i++) begin
            u_core.wr(PAGE_1, TYPE_ADDR[i], 8'hc3 ^ 8'(i));
        end
        for (int i = 0; i < 6; i++) begin
            rchk(PAGE_1, TYPE_ADDR[i], tval(i));
            check(schmitt_en[i], tval(i));
        end
        // page 0 reaches the mode register, not the type registers
        u_core.wr(PAGE_0, 8'hb3, 8'h3c);
        u_core.wr(PAGE_0, 8'hb1, 8'h00);
        u_core.wr(PAGE_0, 8'hb4, 8'hff);
        rchk(PAGE_1, 8'hb3, 8'hc2);
        rchk(PAGE_1, 8'hb1, 8'hc3);
        rchk(PAGE_1, DRIVE_ADDR, 8'h00);
        rchk(PAGE_0, DRIVE_ADDR, 8'h00);
        rchk(PAGE_0, 8'hb3, 8'h3c);
        check(p1_mode_first, 8'h3c);
        // push-pull only on pin 0: first bits 1100, second bits 0101
        @(posedge clock);
        p1_mode_second <= 4'h5;
        u_core.wr(PAGE_1, DRIVE_ADDR, 8'hff);
        rchk(PAGE_1, DRIVE_ADDR, 8'h0f);
        check({4'h0, strength_large}, 8'h01);
        u_core.wr(PAGE_0, 8'hb3, 8'h30);
        repeat (2) @(posedge clock);
        check({4'h0, strength_large}, 8'h05);
        u_core.wr(PAGE_1, DRIVE_ADDR, 8'h0a);
        repeat (2) @(posedge clock);
        check({4'h0, strength_large}, 8'h00);
        // pin 0 leaves push-pull while its strength bit is set
        u_core.wr(PAGE_1, DRIVE_ADDR, 8'h0f);
        u_core.wr(PAGE_0, 8'hb3, 8'h31);
        repeat (2) @(posedge clock);
        check({4'h0, strength_large}, 8'h04);
        rchk(PAGE_1, 8'h80, 8'h00);
        final_report();
    end
endmodule
